// *** shared/dtc_pkg.sv ***
/*
 * Shared constants and types of the block transfer controller.
 * Assumes a single core clock; included by every design file through import.
 */
package dtc_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 32;
	localparam int CNT_W = 24;
	localparam int NUM_CH = 2;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_PTR_W = 3;
	localparam int FIFO_CNT_W = 4;

	// arbitration option codes on prio_mode_i
	localparam logic [1:0] PRIO_CPU_FIRST = 2'h0;
	localparam logic [1:0] PRIO_DMA_FIRST = 2'h1;
	localparam logic [1:0] PRIO_ROTATE = 2'h2;

	// values after reset, and the one-unit count and address steps
	localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
	localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
	localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 24'h000001;

	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_DONE} dtc_state_t;
	typedef enum logic [1:0] {OWN_NONE, OWN_CPU, OWN_DMA} dtc_owner_t;
endpackage

// *** shared/dtc_stream_if.sv ***
/*
 * Valid/ready word stream between the engine and its staging buffer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface dtc_stream_if
	import dtc_pkg::*;
	();
	logic in_valid;
	logic in_ready;
	logic [DATA_W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [DATA_W-1:0] out_data;

	modport buffer (
		input in_valid, in_data, out_ready,
		output in_ready, out_valid, out_data
	);
	modport user (
		output in_valid, in_data, out_ready,
		input in_ready, out_valid, out_data
	);
endinterface
`default_nettype wire

// *** hdl/dtc_fifo.sv ***
/*
 * Flip-flop FIFO staging words between the read and write phases.
 * Assumes synchronous active-high reset; depth is a power of two.
 */
`timescale 1ns/1ns
`default_nettype none
module dtc_fifo
	import dtc_pkg::*;
	#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = FIFO_DEPTH
	) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// stream
	dtc_stream_if.buffer st
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = PW + 1;
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;
	logic [CW-1:0] count_q;
	logic push;
	logic pop;

	assign st.in_ready = (count_q != DEPTH_C);
	assign st.out_valid = (count_q != '0);
	assign st.out_data = mem_q[rd_ptr_q];
	assign push = st.in_valid && st.in_ready;
	assign pop = st.out_valid && st.out_ready;

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem_q[wr_ptr_q] <= st.in_data[WIDTH-1:0];
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + PW'(1);
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + PW'(1);
			end
			case ({push, pop})
				2'b10: count_q <= count_q + CW'(1);
				2'b01: count_q <= count_q - CW'(1);
				default: count_q <= count_q;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** hdl/dtc_top.sv ***
/*
 * Memory-to-memory block transfer controller with its own bus port,
 * bus arbitration against the CPU and an optional second channel.
 * Assumes memory answers a granted request with dma_ack_i, held request.
 */
// Notes on behaviour
// RQ1: each word is first read from the source address, then that word is written to the destination address.
// RQ2: after each word both addresses step up, or down when the direction control selects decrement.
// RQ3: words move back to back until the transfer count has reached zero.
// RQ4: block completion raises a one-cycle interrupt request, produced only when its enable is set.
// RQ5: in the CPU-first option a CPU request always wins over a pending DMA request; the code lets a DMA access awaiting dma_ack_i keep the bus.
// RQ6: in the DMA-first option a pending DMA request always wins over a CPU request; the code lets a granted CPU keep the bus while cpu_req_i stays high.
// RQ7: in the rotating option CPU and DMA alternate, the CPU being granted first.
// RQ8: a second channel with selectable priority exists only in the dual variant; otherwise one channel.
// RQ9: peripheral registers are reached like any memory word, with no special handling.
// RQ10: transfers use the block's own address and data bus, separate from CPU buses.
// RQ11: addresses are 24 bits and data words 32 bits.
// RQ12: the count drops by one per completed word, and a block begins only on a start control.
`timescale 1ns/1ns
`default_nettype none
module dtc_top
	import dtc_pkg::*;
	#(
	parameter bit DUAL_VARIANT = 1'b1
	) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// per-channel control
	input wire logic [NUM_CH-1:0] ch_start_i,
	input wire logic [NUM_CH-1:0] ch_dec_i,
	input wire logic [NUM_CH-1:0] ch_irq_en_i,
	input wire logic [NUM_CH-1:0][ADDR_W-1:0] ch_src_i,
	input wire logic [NUM_CH-1:0][ADDR_W-1:0] ch_dst_i,
	input wire logic [NUM_CH-1:0][CNT_W-1:0] ch_count_i,
	input wire logic ch1_first_i,
	input wire logic [1:0] prio_mode_i,
	// status and interrupt requests
	output logic [NUM_CH-1:0] ch_pending_o,
	output logic busy_o,
	output logic active_ch_o,
	output logic [CNT_W-1:0] count_o,
	output logic [NUM_CH-1:0] irq_o,
	// dma bus (RQ10, RQ11)
	output logic dma_req_o,
	output logic dma_wr_o,
	output logic [ADDR_W-1:0] dma_addr_o,
	output logic [DATA_W-1:0] dma_wdata_o,
	input wire logic [DATA_W-1:0] dma_rdata_i,
	input wire logic dma_ack_i,
	// cpu side of the shared resource
	input wire logic cpu_req_i,
	output logic cpu_gnt_o
);
	dtc_stream_if st ();

	dtc_state_t state_q;
	dtc_owner_t owner_q;
	logic last_cpu_q;
	logic ch_q;
	logic dec_q;
	logic ie_q;
	logic [ADDR_W-1:0] src_q;
	logic [ADDR_W-1:0] dst_q;
	logic [CNT_W-1:0] rd_left_q;
	logic [CNT_W-1:0] cnt_q;
	logic [NUM_CH-1:0] pend_q;
	logic [NUM_CH-1:0] irq_q;
	logic [NUM_CH-1:0] ch_avail;
	logic [1:0] mode;
	logic want;
	logic dma_gnt;
	logic cpu_gnt;
	logic done;
	logic xfer;
	logic pick;

	dtc_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.st(st)
	);

	// second channel and priority choice only in the dual variant
	assign ch_avail = DUAL_VARIANT ? {NUM_CH{1'b1}} : NUM_CH'(1); // RQ8
	assign mode = DUAL_VARIANT ? prio_mode_i : PRIO_CPU_FIRST; // RQ8

	// per-channel start latch and completion request
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			always_ff @(posedge clock_i) begin
				if (rst_i) begin
					pend_q[g] <= 1'b0;
				end else if (ch_start_i[g] && ch_avail[g]) begin
					pend_q[g] <= 1'b1; // RQ12
				end else if (state_q == ST_IDLE && pick == 1'(g) && pend_q[g]) begin
					pend_q[g] <= 1'b0;
				end
			end
			always_ff @(posedge clock_i) begin
				if (rst_i) begin
					irq_q[g] <= 1'b0;
				end else begin
					irq_q[g] <= done && ch_q == 1'(g) && ie_q; // RQ4
				end
			end
		end
	endgenerate

	// channel choice when idle
	always_comb begin
		if (pend_q[0] && pend_q[1]) begin
			pick = ch1_first_i && DUAL_VARIANT; // RQ8
		end else begin
			pick = pend_q[1];
		end
	end

	// bus request: read while buffer has room, write while it holds words
	assign want = (state_q == ST_READ && rd_left_q != CNT_RST && st.in_ready) ||
		(state_q == ST_WRITE && st.out_valid);

	// arbitration of the shared resource
	always_comb begin
		cpu_gnt = 1'b0;
		dma_gnt = 1'b0;
		if (owner_q == OWN_CPU && cpu_req_i) begin
			cpu_gnt = 1'b1;
		end else if (owner_q == OWN_DMA && want) begin
			dma_gnt = 1'b1;
		end else if (cpu_req_i && want) begin
			case (mode)
				PRIO_CPU_FIRST: cpu_gnt = 1'b1; // RQ5
				PRIO_DMA_FIRST: dma_gnt = 1'b1; // RQ6
				PRIO_ROTATE: begin
					cpu_gnt = !last_cpu_q; // RQ7
					dma_gnt = last_cpu_q; // RQ7
				end
				default: cpu_gnt = 1'b1;
			endcase
		end else begin
			cpu_gnt = cpu_req_i;
			dma_gnt = want;
		end
	end

	assign xfer = dma_gnt && dma_ack_i;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			owner_q <= OWN_NONE;
			last_cpu_q <= 1'b0; // RQ7
		end else begin
			if (cpu_gnt) begin
				owner_q <= OWN_CPU;
			end else if (dma_gnt && !dma_ack_i) begin
				owner_q <= OWN_DMA;
			end else begin
				owner_q <= OWN_NONE;
			end
			if (cpu_gnt && owner_q != OWN_CPU) begin
				last_cpu_q <= 1'b1;
			end else if (dma_gnt && owner_q != OWN_DMA) begin
				last_cpu_q <= 1'b0;
			end
		end
	end

	// sequencer
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (pend_q != '0) begin
						state_q <= ST_READ; // RQ12
					end
				end
				ST_READ: begin
					if (!want) begin
						state_q <= ST_WRITE; // RQ1
					end
				end
				ST_WRITE: begin
					if (!st.out_valid) begin
						state_q <= (cnt_q == CNT_RST) ? ST_DONE : ST_READ; // RQ3
					end
				end
				ST_DONE: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	assign done = (state_q == ST_DONE);

	// block setup and address stepping
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			ch_q <= 1'b0;
			dec_q <= 1'b0;
			ie_q <= 1'b0;
			src_q <= ADDR_RST;
			dst_q <= ADDR_RST;
			rd_left_q <= CNT_RST;
			cnt_q <= CNT_RST;
		end else if (state_q == ST_IDLE && pend_q != '0) begin
			ch_q <= pick;
			dec_q <= ch_dec_i[pick];
			ie_q <= ch_irq_en_i[pick];
			src_q <= ch_src_i[pick];
			dst_q <= ch_dst_i[pick];
			rd_left_q <= ch_count_i[pick];
			cnt_q <= ch_count_i[pick];
		end else if (xfer && state_q == ST_READ) begin
			src_q <= dec_q ? src_q - ADDR_STEP : src_q + ADDR_STEP; // RQ2
			rd_left_q <= rd_left_q - CNT_ONE;
		end else if (xfer && state_q == ST_WRITE) begin
			dst_q <= dec_q ? dst_q - ADDR_STEP : dst_q + ADDR_STEP; // RQ2
			cnt_q <= cnt_q - CNT_ONE; // RQ12
		end
	end

	// read data goes to the buffer, buffer head is written out
	assign st.in_valid = xfer && state_q == ST_READ; // RQ1
	assign st.in_data = dma_rdata_i; // RQ11
	assign st.out_ready = xfer && state_q == ST_WRITE; // RQ1

	// any 24-bit address, peripheral or memory, is driven the same way
	assign dma_req_o = dma_gnt; // RQ10
	assign dma_wr_o = (state_q == ST_WRITE);
	assign dma_addr_o = (state_q == ST_WRITE) ? dst_q : src_q; // RQ9
	assign dma_wdata_o = st.out_data;
	assign cpu_gnt_o = cpu_gnt;

	assign ch_pending_o = pend_q;
	assign busy_o = (state_q != ST_IDLE);
	assign active_ch_o = ch_q;
	assign count_o = cnt_q;
	assign irq_o = irq_q;
endmodule
`default_nettype wire

// *** verif/dtc_top_sva.sv ***
/* Port assertions for the block transfer controller.
   Assumes one clock and a bind to dtc_top. */
`timescale 1ns/1ns
`default_nettype none
module dtc_top_sva
	import dtc_pkg::*;
	(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// status
	input wire logic [NUM_CH-1:0] ch_pending_o,
	input wire logic busy_o,
	input wire logic [CNT_W-1:0] count_o,
	input wire logic [NUM_CH-1:0] irq_o,
	input wire logic [1:0] prio_mode_i,
	// buses
	input wire logic dma_req_o,
	input wire logic dma_wr_o,
	input wire logic [ADDR_W-1:0] dma_addr_o,
	input wire logic dma_ack_i,
	input wire logic cpu_req_i,
	input wire logic cpu_gnt_o
);
	// words read and not yet written
	logic [3:0] bal_q;
	always_ff @(posedge clock_i) begin
		if (rst_i || !busy_o) begin
			bal_q <= 4'h0;
		end else if (dma_req_o && dma_ack_i) begin
			bal_q <= dma_wr_o ? bal_q - 4'h1 : bal_q + 4'h1;
		end
	end
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	property p_hold; dma_req_o && !dma_ack_i |=> dma_req_o && $stable(dma_wr_o) && $stable(dma_addr_o);
	endproperty
	a_hold: assert property (p_hold) else $error("access changed before ack");
	property p_order; dma_req_o && dma_wr_o |-> bal_q != 4'h0 && bal_q <= 4'h8;
	endproperty
	a_order: assert property (p_order) else $error("write without a read word");
	property p_excl; !(cpu_gnt_o && dma_req_o);
	endproperty
	a_excl: assert property (p_excl) else $error("both own the resource");
	property p_cpu; prio_mode_i == PRIO_CPU_FIRST && cpu_req_i && !$past(dma_req_o && !dma_ack_i) |->
		cpu_gnt_o && !dma_req_o;
	endproperty
	a_cpu: assert property (p_cpu) else $error("cpu not granted");
	property p_irq; irq_o != 2'h0 |-> !busy_o ##1 irq_o == 2'h0;
	endproperty
	a_irq: assert property (p_irq) else $error("irq not a single pulse");
	property p_begin; $rose(busy_o) |-> $past(ch_pending_o) != 2'h0;
	endproperty
	a_begin: assert property (p_begin) else $error("block without start");
	property p_dec; dma_req_o && dma_wr_o && dma_ack_i |=> count_o == $past(count_o) - CNT_ONE;
	endproperty
	a_dec: assert property (p_dec) else $error("count not decremented");
	property p_done; $fell(busy_o) |-> count_o == CNT_RST && $past(bal_q) == 4'h0;
	endproperty
	a_done: assert property (p_done) else $error("block ended early");
	c_irq: cover property (irq_o != 2'h0);
	c_full: cover property (bal_q == 4'h8);
	c_cpu: cover property (cpu_gnt_o && busy_o);
endmodule
bind dtc_top dtc_top_sva u_sva (.clock_i(clock_i), .rst_i(rst_i), .ch_pending_o(ch_pending_o), .busy_o(busy_o),
	.count_o(count_o), .irq_o(irq_o), .prio_mode_i(prio_mode_i), .dma_req_o(dma_req_o), .dma_wr_o(dma_wr_o),
	.dma_addr_o(dma_addr_o), .dma_ack_i(dma_ack_i), .cpu_req_i(cpu_req_i), .cpu_gnt_o(cpu_gnt_o));
`default_nettype wire

// *** verif/dtc_mem_model.sv ***
/* Memory behind the transfer bus, with wait states.
   Assumes requests are held until ack. */
`timescale 1ns/1ns
`default_nettype none
module dtc_mem_model
	import dtc_pkg::*;
	(
	// bus from the engine
	input wire logic clock_i,
	input wire logic req_i,
	input wire logic wr_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	// wait states
	input wire logic [1:0] wait_i,
	// answer
	output logic [DATA_W-1:0] rdata_o,
	output logic ack_o
);
	logic [DATA_W-1:0] mem [64];
	logic [1:0] cnt_q = 2'h0;
	initial for (int i = 0; i < 64; i++) mem[i] = 32'hC0DE0000 + 32'(i);
	assign ack_o = req_i && cnt_q == wait_i;
	// data shown inverted outside an ack
	assign rdata_o = ack_o ? mem[addr_i[5:0]] : ~mem[addr_i[5:0]];
	always @(posedge clock_i) begin
		cnt_q <= (ack_o || !req_i) ? 2'h0 : cnt_q + 2'h1;
		if (ack_o && wr_i) mem[addr_i[5:0]] <= wdata_i;
	end
endmodule
`default_nettype wire

// *** verif/dtc_top_tb.sv ***
/* Self-checking bench of the transfer controller.
   Assumes the memory model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module dtc_top_tb
	import dtc_pkg::*;
	;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [NUM_CH-1:0] ch_start_i = '0, ch_dec_i = '0, ch_irq_en_i = '0, ch_pending_o, irq_o;
	logic [NUM_CH-1:0][ADDR_W-1:0] ch_src_i = '0, ch_dst_i = '0;
	logic [NUM_CH-1:0][CNT_W-1:0] ch_count_i = '0;
	logic ch1_first_i = 1'b0, cpu_req_i = 1'b0, busy_o, active_ch_o, dma_req_o, dma_wr_o, dma_ack_i, cpu_gnt_o;
	logic [1:0] prio_mode_i = PRIO_CPU_FIRST, wait_q = 2'h0;
	logic [CNT_W-1:0] count_o;
	logic [ADDR_W-1:0] dma_addr_o, ea;
	logic [DATA_W-1:0] dma_wdata_o, dma_rdata_i, ed;
	logic [31:0] seed = 32'h6C37;
	int num_errors = 0, cmp_count = 0, irq_n = 0;
	logic [ADDR_W-1:0] qa[$];
	logic [DATA_W-1:0] qd[$];
	always #5 clock_i = ~clock_i;
	dtc_top DUT (.clock_i(clock_i), .rst_i(rst_i), .ch_start_i(ch_start_i), .ch_dec_i(ch_dec_i),
		.ch_irq_en_i(ch_irq_en_i), .ch_src_i(ch_src_i), .ch_dst_i(ch_dst_i), .ch_count_i(ch_count_i),
		.ch1_first_i(ch1_first_i), .prio_mode_i(prio_mode_i), .ch_pending_o(ch_pending_o), .busy_o(busy_o),
		.active_ch_o(active_ch_o), .count_o(count_o), .irq_o(irq_o), .dma_req_o(dma_req_o), .dma_wr_o(dma_wr_o),
		.dma_addr_o(dma_addr_o), .dma_wdata_o(dma_wdata_o), .dma_rdata_i(dma_rdata_i), .dma_ack_i(dma_ack_i),
		.cpu_req_i(cpu_req_i), .cpu_gnt_o(cpu_gnt_o));
	dtc_mem_model MEM (.clock_i(clock_i), .req_i(dma_req_o), .wr_i(dma_wr_o), .addr_i(dma_addr_o),
		.wdata_i(dma_wdata_o), .wait_i(wait_q), .rdata_o(dma_rdata_i), .ack_o(dma_ack_i));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic test_done;
		$display("errors %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// each written word against the reference queue, at the edge that takes it
	always @(posedge clock_i) begin
		irq_n += int'(irq_o[0]) + int'(irq_o[1]);
		if (dma_req_o && dma_ack_i && dma_wr_o) begin
			if (qa.size() == 0) begin
				`CHK(1'b1, 1'b0)
			end else begin
				ea = qa.pop_front();
				ed = qd.pop_front();
				`CHK(dma_addr_o, ea)
				`CHK(dma_wdata_o, ed)
			end
		end
	end
	// block setup and expected words
	task automatic arm(input int ch, input int n, input bit dec, input bit ie);
		logic [ADDR_W-1:0] s;
		int k;
		s = dec ? 24'h00001F : 24'h000010;
		for (int i = 0; i < n; i++) begin
			k = dec ? -i : i;
			qa.push_back(s + 24'h000010 + 24'(k));
			qd.push_back(MEM.mem[s[5:0] + 6'(k)]);
		end
		ch_src_i[ch] = s;
		ch_dst_i[ch] = s + 24'h000010;
		ch_count_i[ch] = 24'(n);
		ch_dec_i[ch] = dec;
		ch_irq_en_i[ch] = ie;
	endtask
	// waits out one block with random wait states
	task automatic run(input int cpu);
		int t;
		t = 0;
		while (busy_o !== 1'b1 && t < 4) begin
			@(negedge clock_i);
			t++;
		end
		while (busy_o === 1'b1 && t < 500) begin
			@(negedge clock_i);
			seed = lfsr(seed);
			wait_q = seed[2:1];
			if (cpu == 2) cpu_req_i = seed[0];
			t++;
		end
		cpu_req_i = 1'b0;
		@(negedge clock_i);
		`CHK(t < 500, 1'b1)
	endtask
	task automatic blk(input int ch, input int n, input bit dec, input bit ie, input logic [1:0] md, input int cpu);
		int i0;
		i0 = irq_n;
		arm(ch, n, dec, ie);
		prio_mode_i = md;
		cpu_req_i = cpu == 1;
		ch_start_i[ch] = 1'b1;
		@(negedge clock_i);
		ch_start_i[ch] = 1'b0;
		`CHK(ch_pending_o[ch], 1'b1)
		if (cpu == 1) begin
			repeat (20) @(negedge clock_i);
			`CHK(count_o, 24'(n))
			`CHK(cpu_gnt_o, 1'b1)
			cpu_req_i = 1'b0;
		end
		run(cpu);
		`CHK(count_o, CNT_RST)
		`CHK(qa.size(), 0)
		`CHK(irq_n - i0, int'(ie))
		`CHK(active_ch_o, ch[0])
	endtask
	// both channels pending at once: channel 1 chosen first
	task automatic pair;
		int i0;
		i0 = irq_n;
		arm(1, 2, 1'b0, 1'b1);
		arm(0, 3, 1'b1, 1'b1);
		prio_mode_i = PRIO_CPU_FIRST;
		ch1_first_i = 1'b1;
		ch_start_i = 2'h3;
		@(negedge clock_i);
		ch_start_i = 2'h0;
		`CHK(ch_pending_o, 2'h3)
		@(negedge clock_i);
		`CHK(ch_pending_o, 2'h1)
		`CHK(active_ch_o, 1'b1)
		run(0);
		run(0);
		ch1_first_i = 1'b0;
		`CHK(count_o, CNT_RST)
		`CHK(qa.size(), 0)
		`CHK(irq_n - i0, 2)
		`CHK(active_ch_o, 1'b0)
	endtask
	initial begin
		#80000;
		num_errors++;
		test_done;
	end
	initial begin
		repeat (6) @(negedge clock_i);
		rst_i = 1'b0;
		blk(0, 3, 1'b0, 1'b1, PRIO_CPU_FIRST, 0);
		blk(1, 10, 1'b1, 1'b1, PRIO_DMA_FIRST, 2);
		blk(0, 0, 1'b0, 1'b1, PRIO_CPU_FIRST, 0);
		blk(1, 5, 1'b0, 1'b0, PRIO_ROTATE, 2);
		blk(0, 2, 1'b1, 1'b1, PRIO_CPU_FIRST, 1);
		blk(0, 4, 1'b0, 1'b1, 2'h3, 2);
		pair;
		test_done;
	end
endmodule
`default_nettype wire
